/* File: rtl/pwt_pkg.sv */
// Package for the pulse width timer with frequency divider.
// Assumes one 250 MHz clock; all software bits arrive as same-clock ports.
package pwt_pkg;

  // Control byte layout
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_RUN = 4;
  localparam int CTRL_EDGE = 3;
  localparam int CTRL_PSC_HI = 2;
  localparam int CTRL_PSC_LO = 0;

  // Mode pair encodings
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h3;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PRELOAD_RESET = 8'h00;

  // Counting limits
  localparam logic [7:0] COUNT_FULL = 8'hFF;
  localparam int NUM_CNT = 2;

  // Prescaler: ratio 2**select, select 0 passes every clock
  localparam int PSC_DIV_W = 7;
  localparam logic [PSC_DIV_W-1:0] PSC_DIV_RESET = 7'h00;

  // Clock figure
  localparam int CLK_PERIOD_NS = 4;

  // Software strobes, all one-cycle pulses, index = counter number
  typedef struct packed {
    logic [1:0] ctrl_wr;
    logic [1:0] preload_wr;
    logic [1:0] cnt_rd;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [7:0] data;
  } pwt_sw_t;

  // Readback of both counters
  typedef struct packed {
    logic [1:0][7:0] count;
    logic [1:0][7:0] ctrl;
  } pwt_cnt_t;

endpackage

/* File: rtl/pwt_pin_sync.sv */
// Three-stage synchroniser with edge pulses for one timer input pin.
// Assumes the pin is asynchronous to REF_CLK_IN; edges come out three
// to four clocks late.
`timescale 1ns/1ps
module pwt_pin_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  import pwt_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
    logic [1:0] fill;
  } pwt_sync_t;

  pwt_sync_t q;
  pwt_sync_t d;

  // A change counts only once stages two and three agree, filtering a glitch
  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rise = 1'b0;
    d.fall = 1'b0;
    if (q.fill != 2'h3) begin
      // Adopt the pin level quietly while the stages fill, so reset gives no false edge
      d.fill = q.fill + 2'h1;
      d.level = q.s2;
    end else if ((q.s2 == q.s3) && (q.s3 != q.level)) begin
      d.level = q.s3;
      d.rise = q.s3;
      d.fall = ~q.s3;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_out = q.level;
  assign rise_out = q.rise;
  assign fall_out = q.fall;

endmodule

/* File: rtl/pwt_timer.sv */
// Operation
// - Both mode bits set select pulse measurement
// - Pulse mode counts internal clock, pin gates
// - Edge select low: fall starts, rise stops
// - Edge select high: rise starts, fall stops
// - Only pulse mode clears run in hardware
// - Finished measurement value held and readable
// - After stop, edges ignored until rearmed
// - Start and stop follow edges, not levels
// - Overflow signals, reloads preload, keeps counting
// - Overflow sets flag; enable gates interrupt
// - Overflow wakes from power-down regardless of enable
// - Flag already set blocks overflow wake-up
// - Divider output toggles on counter 0 overflow
// - Divider shown only when gate bit set
// - Pin set as input: divider not driving
// - Three-bit prescaler feeds counter 0 only
// - Pin events act at next timer clock
// - Reads and preload writes inhibit counting
// - Count up from preload to FFH overflow
// - Stopped preload write loads counter immediately
// - Control bits: mode 7:6, run 4, edge 3, prescale 2:0
//
// Two 8-bit counters with pulse width measurement and the divider pin.
// Assumes software strobes are one-cycle pulses on REF_CLK_IN and that the
// timer input pins are asynchronous.
`timescale 1ns/1ps
module pwt_timer (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire pwt_pkg::pwt_sw_t SW_IN,
  input wire logic [1:0] IRQ_EN_IN,
  input wire logic POWER_DOWN_IN,
  input wire logic [1:0] CNT_PIN_IN,
  input wire logic PFD_OPTION_IN,
  input wire logic PORT_A_DIRECTION3_IN,
  input wire logic DIVIDER_GATE_BIT_IN,
  output pwt_pkg::pwt_cnt_t CNT_STATUS_OUT,
  output logic [1:0] OVF_OUT,
  output logic [1:0] IRQ_FLAG_OUT,
  output logic [1:0] IRQ_OUT,
  output logic WAKE_OUT,
  output logic FREQ_DIVIDER_OUT_O_OUT,
  output logic FREQ_DIVIDER_OUT_OE_N_OUT
);
  import pwt_pkg::*;

  typedef struct packed {
    logic [1:0][7:0] count;
    logic [1:0][7:0] preload;
    logic [1:0][7:0] ctrl;
    logic [1:0] meas;
    logic [1:0] ovf;
    logic [1:0] flag;
    logic [PSC_DIV_W-1:0] div;
    logic freq_divider_out;
    logic wake;
    logic pin_o;
    logic pin_oe_n;
  } pwt_state_t;

  pwt_state_t q;
  pwt_state_t d;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  // Pin synchronisers; events reach the counter only on a later clock
  pwt_pin_sync u_sync0 (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .pin_in(CNT_PIN_IN[0]),
    .level_out(),
    .rise_out(pin_rise[0]),
    .fall_out(pin_fall[0])
  );

  pwt_pin_sync u_sync1 (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .pin_in(CNT_PIN_IN[1]),
    .level_out(),
    .rise_out(pin_rise[1]),
    .fall_out(pin_fall[1])
  );

  always_comb begin
    logic [2:0] psc;
    logic [PSC_DIV_W-1:0] psc_mask;
    logic tick0;
    logic [1:0] mode;
    logic run;
    logic esel;
    logic start_edge;
    logic stop_edge;
    logic evt_edge;
    logic tick;
    logic inc;
    psc = 3'h0;
    psc_mask = '0;
    tick0 = 1'b0;
    mode = 2'h0;
    run = 1'b0;
    esel = 1'b0;
    start_edge = 1'b0;
    stop_edge = 1'b0;
    evt_edge = 1'b0;
    tick = 1'b0;
    inc = 1'b0;
    d = q;
    d.ovf = 2'h0;
    d.wake = 1'b0;
    // Prescaler on counter 0 only; the free divider avoids a per-mode reset
    psc = q.ctrl[0][CTRL_PSC_HI:CTRL_PSC_LO];
    psc_mask = PSC_DIV_W'((8'h01 << psc) - 8'h01);
    tick0 = ((q.div & psc_mask) == psc_mask);
    d.div = q.div + 7'h01;
    for (int i = 0; i < NUM_CNT; i++) begin
      mode = q.ctrl[i][CTRL_MODE_HI:CTRL_MODE_LO];
      run = q.ctrl[i][CTRL_RUN];
      esel = q.ctrl[i][CTRL_EDGE];
      start_edge = esel ? pin_rise[i] : pin_fall[i];
      stop_edge = esel ? pin_fall[i] : pin_rise[i];
      evt_edge = esel ? pin_fall[i] : pin_rise[i];
      tick = (i == 0) ? tick0 : 1'b1;
      // Edges arm and end a measurement, never the static level
      if (run && (mode == MODE_PULSE)) begin
        if (!q.meas[i] && start_edge) begin
          d.meas[i] = 1'b1;
        end else if (q.meas[i] && stop_edge) begin
          d.meas[i] = 1'b0;
          d.ctrl[i][CTRL_RUN] = 1'b0;
        end
      end
      case (mode)
        MODE_TIMER: inc = tick;
        MODE_EVENT: inc = evt_edge;
        MODE_PULSE: inc = q.meas[i] && !stop_edge && tick;
        default: inc = 1'b0;
      endcase
      // Clock inhibited during reads and preload writes; counts may be lost
      inc = inc && run && !SW_IN.cnt_rd[i] && !SW_IN.preload_wr[i];
      if (inc) begin
        if (q.count[i] == COUNT_FULL) begin
          d.count[i] = q.preload[i];
          d.ovf[i] = 1'b1;
        end else begin
          d.count[i] = q.count[i] + 8'h01;
        end
      end
      if (SW_IN.preload_wr[i]) begin
        d.preload[i] = SW_IN.data;
        if (!run) begin
          d.count[i] = SW_IN.data;
        end
      end
      // A software write wins over the hardware run clear of the same cycle
      if (SW_IN.ctrl_wr[i]) begin
        d.ctrl[i] = SW_IN.data;
        d.meas[i] = 1'b0;
      end
      if (SW_IN.flag_clr[i]) begin
        d.flag[i] = 1'b0;
      end
      if (SW_IN.flag_set[i] || d.ovf[i]) begin
        d.flag[i] = 1'b1;
      end
      // Wake ignores enables; a flag already set suppresses it
      if (d.ovf[i] && POWER_DOWN_IN && !q.flag[i]) begin
        d.wake = 1'b1;
      end
    end
    if (d.ovf[0]) begin
      d.freq_divider_out = ~q.freq_divider_out;
    end
    d.pin_oe_n = !(PFD_OPTION_IN && !PORT_A_DIRECTION3_IN);
    d.pin_o = !d.pin_oe_n && DIVIDER_GATE_BIT_IN && d.freq_divider_out;
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q.count <= {NUM_CNT{COUNT_RESET}};
      q.preload <= {NUM_CNT{PRELOAD_RESET}};
      q.ctrl <= {NUM_CNT{CTRL_RESET}};
      q.meas <= 2'h0;
      q.ovf <= 2'h0;
      q.flag <= 2'h0;
      q.div <= PSC_DIV_RESET;
      q.freq_divider_out <= 1'b0;
      q.wake <= 1'b0;
      q.pin_o <= 1'b0;
      q.pin_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign CNT_STATUS_OUT.count = q.count;
  assign CNT_STATUS_OUT.ctrl = q.ctrl;
  assign OVF_OUT = q.ovf;
  assign IRQ_FLAG_OUT = q.flag;
  assign IRQ_OUT = q.flag & IRQ_EN_IN;
  assign WAKE_OUT = q.wake;
  assign FREQ_DIVIDER_OUT_O_OUT = q.pin_o;
  assign FREQ_DIVIDER_OUT_OE_N_OUT = q.pin_oe_n;

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  property p_stop_low_sel;
    q.meas[1] && !q.ctrl[1][CTRL_EDGE] && pin_rise[1] && q.ctrl[1][CTRL_RUN]
      && (q.ctrl[1][CTRL_MODE_HI:CTRL_MODE_LO] == MODE_PULSE) && !SW_IN.ctrl_wr[1]
      |=> !q.ctrl[1][CTRL_RUN] && !q.meas[1];
  endproperty
  a_stop_low_sel: assert property (p_stop_low_sel)
    else $error("pulse mode did not stop on rising edge");

  property p_start_high_sel;
    !q.meas[1] && q.ctrl[1][CTRL_EDGE] && pin_rise[1] && q.ctrl[1][CTRL_RUN]
      && (q.ctrl[1][CTRL_MODE_HI:CTRL_MODE_LO] == MODE_PULSE) && !SW_IN.ctrl_wr[1]
      |=> q.meas[1] ##1 (q.meas[1] || !q.ctrl[1][CTRL_RUN]);
  endproperty
  a_start_high_sel: assert property (p_start_high_sel)
    else $error("pulse mode did not start on rising edge");

  property p_run_clear_pulse_only;
    $fell(q.ctrl[1][CTRL_RUN]) && !$past(SW_IN.ctrl_wr[1])
      |-> $past(q.ctrl[1][CTRL_MODE_HI:CTRL_MODE_LO]) == MODE_PULSE;
  endproperty
  a_run_clear_pulse_only: assert property (p_run_clear_pulse_only)
    else $error("run bit cleared outside pulse mode");

  property p_hold_after_stop;
    !q.ctrl[1][CTRL_RUN] && !SW_IN.preload_wr[1] |=> $stable(q.count[1]);
  endproperty
  a_hold_after_stop: assert property (p_hold_after_stop)
    else $error("stopped counter changed");

  property p_ovf_reload;
    q.ovf[0] |-> $past(q.count[0]) == COUNT_FULL && q.count[0] == $past(q.preload[0]);
  endproperty
  a_ovf_reload: assert property (p_ovf_reload)
    else $error("overflow did not reload preload");

  property p_ovf_flag;
    q.ovf[1] |-> q.flag[1] && (IRQ_OUT[1] == IRQ_EN_IN[1]);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow did not raise flag");

  property p_wake;
    q.ovf[1] && $past(POWER_DOWN_IN) && !$past(q.flag[1]) |-> WAKE_OUT;
  endproperty
  a_wake: assert property (p_wake)
    else $error("overflow in power-down gave no wake");

  property p_wake_blocked;
    WAKE_OUT |-> (q.ovf[0] && !$past(q.flag[0])) || (q.ovf[1] && !$past(q.flag[1]));
  endproperty
  a_wake_blocked: assert property (p_wake_blocked)
    else $error("wake without fresh overflow");

  property p_pfd_toggle;
    q.ovf[0] |-> q.freq_divider_out != $past(q.freq_divider_out);
  endproperty
  a_pfd_toggle: assert property (p_pfd_toggle)
    else $error("divider did not toggle");

  property p_pfd_gate;
    !$past(DIVIDER_GATE_BIT_IN) |-> !FREQ_DIVIDER_OUT_O_OUT;
  endproperty
  a_pfd_gate: assert property (p_pfd_gate)
    else $error("divider pin high with gate bit clear");

  property p_pfd_input;
    $past(PORT_A_DIRECTION3_IN) |-> FREQ_DIVIDER_OUT_OE_N_OUT;
  endproperty
  a_pfd_input: assert property (p_pfd_input)
    else $error("divider drives an input pin");

  property p_inhibit;
    SW_IN.cnt_rd[1] && !SW_IN.preload_wr[1] && !SW_IN.ctrl_wr[1] |=> $stable(q.count[1]);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("counter moved during read");

  property p_stopped_load;
    SW_IN.preload_wr[1] && !q.ctrl[1][CTRL_RUN] |=> q.count[1] == $past(SW_IN.data);
  endproperty
  a_stopped_load: assert property (p_stopped_load)
    else $error("stopped preload write not loaded");

  property p_pulse_counts;
    q.meas[1] && q.ctrl[1][CTRL_RUN] && (q.ctrl[1][CTRL_MODE_HI:CTRL_MODE_LO] == MODE_PULSE)
      && !pin_rise[1] && !pin_fall[1] && !SW_IN.cnt_rd[1] && !SW_IN.preload_wr[1]
      && (q.count[1] != COUNT_FULL) |=> q.count[1] == $past(q.count[1]) + 8'h01;
  endproperty
  a_pulse_counts: assert property (p_pulse_counts)
    else $error("pulse mode missed an internal clock count");

  property p_no_count_unarmed;
    !q.meas[1] && (q.ctrl[1][CTRL_MODE_HI:CTRL_MODE_LO] == MODE_PULSE)
      && !SW_IN.preload_wr[1]
      |=> $stable(q.count[1]);
  endproperty
  a_no_count_unarmed: assert property (p_no_count_unarmed)
    else $error("pulse mode counted before a start edge");

  property p_stay_disarmed;
    !q.ctrl[1][CTRL_RUN] && !SW_IN.ctrl_wr[1] |=> !q.meas[1];
  endproperty
  a_stay_disarmed: assert property (p_stay_disarmed)
    else $error("stopped counter armed by a pin edge");

  property p_run_kept;
    (q.ctrl[1][CTRL_MODE_HI:CTRL_MODE_LO] != MODE_PULSE) && q.ctrl[1][CTRL_RUN]
      && !SW_IN.ctrl_wr[1] |=> q.ctrl[1][CTRL_RUN];
  endproperty
  a_run_kept: assert property (p_run_kept)
    else $error("run bit cleared by hardware outside pulse mode");

  property p_ovf_at_full;
    q.ovf[1] |-> $past(q.count[1]) == COUNT_FULL;
  endproperty
  a_ovf_at_full: assert property (p_ovf_at_full)
    else $error("overflow away from the full count");

  property p_prescale_gap;
    (q.ctrl[0][CTRL_MODE_HI:CTRL_MODE_LO] == MODE_TIMER) && q.ctrl[0][CTRL_RUN]
      && (q.ctrl[0][CTRL_PSC_HI:CTRL_PSC_LO] != 3'h0) && $stable(q.ctrl[0])
      && $changed(q.count[0]) |=> $stable(q.count[0]);
  endproperty
  a_prescale_gap: assert property (p_prescale_gap)
    else $error("prescaled counter stepped on consecutive clocks");

  property p_sync_delay;
    pin_rise[1] |-> $past(CNT_PIN_IN[1], 3) && $past(CNT_PIN_IN[1], 4);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("pin edge reported before the pin settled");

  c_ovf0: cover property (q.ovf[0]);
  c_measure_done: cover property ($fell(q.meas[1]) && !q.ctrl[1][CTRL_RUN]);
  c_wake: cover property (WAKE_OUT);
  c_pfd_high: cover property ($rose(FREQ_DIVIDER_OUT_O_OUT));
  c_event_step: cover property ((q.ctrl[1][CTRL_MODE_HI:CTRL_MODE_LO] == MODE_EVENT)
    && $changed(q.count[1]));

endmodule

/* File: test/pwt_far_end.sv */
// Far-side model: pulse source on both timer pins and the load on the divider pin.
// Assumes the bench calls its tasks; pins move off the clock edge.
`timescale 1ns/1ps
module pwt_far_end (
  input wire logic clk_in,
  input wire logic o_in,
  input wire logic oe_n_in,
  output logic [1:0] pin_out,
  output wire logic div_pin_out
);
  logic last_q = 1'b0;
  // No pull on the pin: once released it shows the inverse of what the block last drove
  assign div_pin_out = oe_n_in ? ~last_q : o_in;
  always @(posedge clk_in) begin
    if (!oe_n_in) last_q <= o_in;
  end
  initial pin_out = 2'h3;
  // Pins change 1.3 ns after the edge, unrelated to sampling
  task automatic set_pin(input int i, input logic v);
    @(posedge clk_in);
    #1.3 pin_out[i] = v;
  endtask
  task automatic pulse(input int i, input logic act, input int len);
    set_pin(i, act);
    repeat (len - 1) @(posedge clk_in);
    set_pin(i, ~act);
  endtask
endmodule

/* File: test/pwt_timer_bench.sv */
// Self-checking bench for the pulse width timer and divider.
// Assumes pwt_far_end drives the pins; software strobes are one-cycle pulses.
`timescale 1ns/1ps
module pwt_timer_bench;
  import pwt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pwt_sw_t sw = '0;
  logic [1:0] irq_en = 2'h0;
  logic pd = 1'b0;
  logic opt = 1'b0;
  logic dir = 1'b1;
  logic gate = 1'b0;
  logic [1:0] pins, ovf, flag, irq;
  wire logic div_pin;
  pwt_cnt_t st;
  logic wake, pfd_o, pfd_oe_n, lastpin;
  int miscompares = 0;
  int n_checks = 0;
  int wakes, n, tog, p, q, len, d;
  always #2 clk = ~clk;
  pwt_timer pwt_timer_inst (.REF_CLK_IN(clk), .RST_IN(rst), .SW_IN(sw), .IRQ_EN_IN(irq_en),
    .POWER_DOWN_IN(pd), .CNT_PIN_IN(pins), .PFD_OPTION_IN(opt), .PORT_A_DIRECTION3_IN(dir),
    .DIVIDER_GATE_BIT_IN(gate), .CNT_STATUS_OUT(st), .OVF_OUT(ovf), .IRQ_FLAG_OUT(flag),
    .IRQ_OUT(irq), .WAKE_OUT(wake), .FREQ_DIVIDER_OUT_O_OUT(pfd_o),
    .FREQ_DIVIDER_OUT_OE_N_OUT(pfd_oe_n));
  pwt_far_end pwt_far_end_inst (.clk_in(clk), .o_in(pfd_o), .oe_n_in(pfd_oe_n),
    .pin_out(pins), .div_pin_out(div_pin));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s ended", s);
  endtask
  task automatic put(input pwt_sw_t v);
    @(posedge clk);
    sw <= v;
    @(posedge clk);
    sw <= '0;
    #1;
  endtask
  task automatic wctrl(input int i, input logic [7:0] v);
    put({2'(1 << i), 8'h00, v});
  endtask
  task automatic wpre(input int i, input logic [7:0] v);
    put({2'h0, 2'(1 << i), 6'h00, v});
  endtask
  // Counts cycles, wake pulses and divider pin changes up to the next overflow
  task automatic wait_ovf(input int i);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      wakes += int'(wake);
      tog += int'(div_pin !== lastpin);
      lastpin = div_pin;
      if (n > 3000) begin
        $display("unexpected at %0t: no overflow", $time);
        miscompares++;
        summarize();
      end
    end while (ovf[i] !== 1'b1);
  endtask
  initial begin
    void'($urandom(32'h084bd3bc));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(pfd_oe_n, 1'b1);
    chk(st.count[1], COUNT_RESET);
    done("reset");
    wctrl(0, 8'h80);
    wpre(0, 8'hF0);
    @(posedge clk) {opt, dir, gate} <= 3'h5;
    repeat (2) @(posedge clk);
    #1;
    chk(pfd_oe_n, 1'b0);
    chk(div_pin, 1'b0);
    wctrl(0, 8'h90);
    wait_ovf(0);
    tog = 0;
    lastpin = div_pin;
    repeat (8) wait_ovf(0);
    chk(tog, 8);
    @(posedge clk) gate <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    chk(div_pin, 1'b0);
    @(posedge clk) dir <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(pfd_oe_n, 1'b1);
    done("divider");
    for (int s = 0; s < 8; s++) begin
      wctrl(0, 8'(8'h80 + s));
      wpre(0, 8'hFE);
      wctrl(0, 8'(8'h90 + s));
      wait_ovf(0);
      wait_ovf(0);
      chk(n, 2 << s);
    end
    done("prescaler");
    p = 8'h80 + $urandom % 127;
    wctrl(1, 8'h87);
    wpre(1, p[7:0]);
    chk(st.count[1], p);
    wctrl(1, 8'h97);
    chk(st.ctrl[1], 8'h97);
    @(posedge clk) irq_en <= 2'h2;
    wait_ovf(1);
    chk(st.count[1], p);
    chk(flag[1], 1'b1);
    chk(irq[1], 1'b1);
    wait_ovf(1);
    chk(n, 256 - p);
    q = 8'hC0 + $urandom % 63;
    wpre(1, q[7:0]);
    wait_ovf(1);
    chk(st.count[1], q);
    wait_ovf(1);
    chk(n, 256 - q);
    chk(st.ctrl[1][CTRL_RUN], 1'b1);
    // A read strobe costs one tick; two of the period's cycles pass inside put
    put({4'h0, 2'h2, 4'h0, 8'h00});
    wait_ovf(1);
    chk(n, 256 - q - 1);
    @(posedge clk) irq_en <= 2'h0;
    #1;
    chk(irq[1], 1'b0);
    done("timer");
    put({8'h00, 2'h2, 8'h00});
    @(posedge clk) pd <= 1'b1;
    wakes = 0;
    wait_ovf(1);
    @(posedge clk);
    #1;
    wakes += int'(wake);
    chk(wakes, 1);
    // Clear the flag the overflow left, so the software set below is what blocks the wake
    put({8'h00, 2'h2, 8'h00});
    chk(flag[1], 1'b0);
    put({6'h00, 2'h2, 2'h0, 8'h00});
    chk(flag[1], 1'b1);
    wakes = 0;
    wait_ovf(1);
    @(posedge clk);
    #1;
    wakes += int'(wake);
    chk(wakes, 0);
    @(posedge clk) pd <= 1'b0;
    done("wake");
    for (int e = 0; e < 2; e++) begin
      wctrl(1, 8'(8'hC0 + 8 * e));
      wpre(1, 8'h00);
      pwt_far_end_inst.set_pin(1, e[0]);
      repeat (6) @(posedge clk);
      wctrl(1, 8'(8'hD0 + 8 * e));
      repeat (10) @(posedge clk);
      #1;
      chk(st.count[1], 8'h00);
      pwt_far_end_inst.set_pin(1, ~e[0]);
      repeat (8) @(posedge clk);
      #1;
      chk(st.ctrl[1][CTRL_RUN], 1'b1);
      len = 5 + $urandom % 60;
      pwt_far_end_inst.pulse(1, e[0], len);
      repeat (8) @(posedge clk);
      #1;
      chk(st.ctrl[1][CTRL_RUN], 1'b0);
      d = int'(st.count[1]) - len;
      chk(d >= -1 && d <= 1, 1'b1);
      pwt_far_end_inst.pulse(1, e[0], 20);
      repeat (8) @(posedge clk);
      #1;
      chk(st.count[1], 8'(len + d));
    end
    done("pulse");
    wctrl(1, 8'h40);
    wpre(1, 8'h00);
    wctrl(1, 8'h50);
    n = 1 + $urandom % 9;
    repeat (n) begin
      pwt_far_end_inst.pulse(1, 1'b1, 3);
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    #1;
    chk(st.count[1], 8'(n));
    chk(st.ctrl[1][CTRL_RUN], 1'b1);
    done("event");
    // Pin high across a reset must not look like a fresh edge afterwards
    pwt_far_end_inst.set_pin(1, 1'b1);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wctrl(1, 8'h40);
    wctrl(1, 8'h50);
    repeat (8) @(posedge clk);
    #1;
    chk(st.count[1], COUNT_RESET);
    chk(pfd_oe_n, 1'b1);
    done("reset again");
    summarize();
  end
endmodule
